// [hdl/ssc_pkg.sv]
// constants shared by the sideband statistics counter block
package ssc_pkg;
	// ------------------------------------------------------------
	// frame length limits, destination address through fcs
	// ------------------------------------------------------------
	localparam int unsigned LEN_W          = 14;
	localparam logic [13:0] LEN_MIN        = 14'h0040;
	localparam logic [13:0] LEN_BIN1_HI    = 14'h007F;
	localparam logic [13:0] LEN_BIN2_LO    = 14'h0080;
	localparam logic [13:0] LEN_BIN2_HI    = 14'h00FF;
	localparam logic [13:0] LEN_BIN3_LO    = 14'h0100;
	localparam logic [13:0] LEN_BIN3_HI    = 14'h01FF;
	localparam logic [13:0] LEN_BIN4_LO    = 14'h0200;
	localparam logic [13:0] LEN_BIN4_HI    = 14'h03FF;
	localparam logic [13:0] LEN_BIN5_LO    = 14'h0400;
	localparam logic [13:0] LEN_BIN5_HI    = 14'h05F2;
	localparam logic [13:0] LEN_OVERSIZE   = 14'h05F3;

	// ------------------------------------------------------------
	// lan counter numbering and cleared-flag words
	// ------------------------------------------------------------
	localparam int unsigned NUM_CTRS       = 39;
	localparam logic [5:0]  LAN_FIRST      = 6'h1B;
	localparam logic [5:0]  LAN_LAST       = 6'h26;
	localparam int unsigned LAN_NUM        = 12;
	localparam int unsigned LAN_W          = 64;
	localparam int unsigned FLAG_LO_BITS   = 32;
	localparam int unsigned FLAG_HI_BITS   = 7;
	localparam logic [24:0] FLAG_HI_RSVD   = 25'h0000000;
	localparam int unsigned IX_RX_BIN5     = 0;
	localparam int unsigned IX_RX_OVER     = 1;
	localparam int unsigned IX_TX_BIN0     = 2;
	localparam int unsigned IX_TX_BIN1     = 3;
	localparam int unsigned IX_TX_BIN2     = 4;
	localparam int unsigned IX_TX_BIN3     = 5;
	localparam int unsigned IX_TX_BIN4     = 6;
	localparam int unsigned IX_TX_BIN5     = 7;
	localparam int unsigned IX_TX_OVER     = 8;
	localparam int unsigned IX_RX_BYTES    = 9;
	localparam int unsigned IX_RX_RUNT     = 10;
	localparam int unsigned IX_RX_JABBER   = 11;

	// ------------------------------------------------------------
	// sideband statistics command and response
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_SB_STATS   = 8'h19;
	localparam logic [7:0]  CMD_PT_STATS   = 8'h1A;
	localparam logic [7:0]  RSP_SB_STATS   = 8'h99;
	localparam logic [15:0] RSP_CODE_OK    = 16'h0000;
	localparam logic [15:0] RSN_CODE_NONE  = 16'h0000;
	localparam int unsigned SB_NUM         = 7;
	localparam int unsigned SB_W           = 32;
	localparam logic [2:0]  SB_LAST_WORD   = 3'h7;
	localparam logic [31:0] CTR_UNSUPP     = 32'hFFFFFFFF;
	localparam int unsigned IX_SB_CMDS     = 0;
	localparam int unsigned IX_SB_DROPS    = 1;
	localparam int unsigned IX_SB_UNSUPP   = 2;
	localparam int unsigned IX_SB_CSUM     = 3;
	localparam int unsigned IX_SB_RX       = 4;
	localparam int unsigned IX_SB_TX       = 5;
	localparam int unsigned IX_SB_NOTICE   = 6;

	typedef enum logic [0:0] {
		SSC_IDLE,
		SSC_SEND
	} ssc_state_t;
endpackage : ssc_pkg

// [hdl/ssc_counter.sv]
// one statistics counter with clear, variable increment and optional hold below all ones
`timescale 1ns/1ps
module ssc_counter #(
	parameter int unsigned W   = 32,
	parameter int unsigned IW  = 2,
	parameter bit          SAT = 1'b1
) (
	input  wire logic          mclk_in,
	input  wire logic          resetn_in,
	input  wire logic          ce_in,
	input  wire logic          clr_in,
	input  wire logic [IW-1:0] inc_in,
	output logic      [W-1:0]  val_out
);
	// hold value: all ones minus one, all ones is reserved for unsupported
	localparam logic [W-1:0] CAP = {{(W-1){1'b1}}, 1'b0};

	logic [W-1:0] val_r;
	logic [W-1:0] val_nxt;
	wire  [W-1:0] base_w = clr_in ? '0 : val_r;
	wire  [W:0]   sum_w  = {1'b0, base_w} + {{(W+1-IW){1'b0}}, inc_in};
	wire          over_w = SAT && (sum_w > {1'b0, CAP});

	// an event in the clearing cycle is counted from zero
	assign val_nxt = over_w ? CAP : sum_w[W-1:0];
	assign val_out = val_r;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			val_r <= '0;
		end else if (ce_in) begin
			val_r <= val_nxt;
		end
	end
endmodule : ssc_counter

// [hdl/ssc_stats.sv]
// upper lan packet counters, cleared flags and sideband statistics response
`timescale 1ns/1ps
module ssc_stats #(
	parameter bit CSUM_CHECK_EN  = 1'b1,
	parameter bit COUNT_BAD_CHAN = 1'b0
) (
	input  wire logic                         mclk_in,
	input  wire logic                         resetn_in,
	input  wire logic                         ce_in,
	input  wire logic                         rx_done_in,
	input  wire logic [ssc_pkg::LEN_W-1:0]    rx_len_in,
	input  wire logic                         rx_fcs_ok_in,
	input  wire logic                         rx_err_in,
	input  wire logic                         rx_addr_pass_in,
	input  wire logic [ssc_pkg::LEN_W-1:0]    rx_mtu_in,
	input  wire logic                         tx_done_in,
	input  wire logic [ssc_pkg::LEN_W-1:0]    tx_len_in,
	input  wire logic                         tx_good_in,
	input  wire logic                         tx_addr_pass_in,
	input  wire logic [ssc_pkg::NUM_CTRS-1:0] host_clear_in,
	input  wire logic                         stats_read_in,
	input  wire logic                         lan_rd_req_in,
	input  wire logic [5:0]                   lan_rd_sel_in,
	input  wire logic                         init_state_in,
	input  wire logic                         cmd_ok_in,
	input  wire logic                         msg_drop_in,
	input  wire logic                         drop_bad_chan_in,
	input  wire logic                         cmd_unsupp_in,
	input  wire logic                         csum_drop_in,
	input  wire logic                         resp_sent_in,
	input  wire logic                         async_event_notice_sent_in,
	input  wire logic                         cmd_valid_in,
	input  wire logic [7:0]                   cmd_type_in,
	output logic                              lan_rd_valid_out,
	output logic      [ssc_pkg::LAN_W-1:0]    lan_rd_data_out,
	output logic      [31:0]                  cleared_lo_out,
	output logic      [31:0]                  cleared_hi_out,
	output logic                              resp_valid_out,
	output logic                              resp_last_out,
	output logic      [7:0]                   resp_type_out,
	output logic      [31:0]                  resp_word_out,
	output logic                              pt_req_out
);
	localparam int unsigned LW = ssc_pkg::LEN_W;

	// ------------------------------------------------------------
	// frame classification
	// ------------------------------------------------------------
	// good means fcs valid and no other error flagged
	wire rx_good_w = rx_done_in && rx_fcs_ok_in && !rx_err_in;
	wire tx_good_w = tx_done_in && tx_good_in;

	wire rx_bin5_w = rx_good_w && (rx_len_in >= ssc_pkg::LEN_BIN5_LO)
		&& (rx_len_in <= ssc_pkg::LEN_BIN5_HI);
	wire rx_over_w = rx_done_in && rx_addr_pass_in
		&& (rx_len_in > ssc_pkg::LEN_OVERSIZE);
	wire tx_over_w = tx_done_in && tx_addr_pass_in
		&& (tx_len_in > ssc_pkg::LEN_OVERSIZE);
	wire tx_bin0_w = tx_good_w && (tx_len_in == ssc_pkg::LEN_MIN);
	wire tx_bin1_w = tx_good_w && (tx_len_in > ssc_pkg::LEN_MIN)
		&& (tx_len_in <= ssc_pkg::LEN_BIN1_HI);
	wire tx_bin2_w = tx_good_w && (tx_len_in >= ssc_pkg::LEN_BIN2_LO)
		&& (tx_len_in <= ssc_pkg::LEN_BIN2_HI);
	wire tx_bin3_w = tx_good_w && (tx_len_in >= ssc_pkg::LEN_BIN3_LO)
		&& (tx_len_in <= ssc_pkg::LEN_BIN3_HI);
	wire tx_bin4_w = tx_good_w && (tx_len_in >= ssc_pkg::LEN_BIN4_LO)
		&& (tx_len_in <= ssc_pkg::LEN_BIN4_HI);
	wire tx_bin5_w = tx_good_w && (tx_len_in >= ssc_pkg::LEN_BIN5_LO)
		&& (tx_len_in <= ssc_pkg::LEN_BIN5_HI);
	// runts with a valid fcs belong to a lower counter, so only bad ones here
	wire rx_runt_w = rx_done_in && !rx_fcs_ok_in
		&& (rx_len_in < ssc_pkg::LEN_MIN);
	wire rx_jab_w  = rx_done_in && !rx_fcs_ok_in && (rx_len_in > rx_mtu_in);

	// ------------------------------------------------------------
	// lan counters 27 to 38
	// ------------------------------------------------------------
	wire [LW-1:0]             lan_inc [0:ssc_pkg::LAN_NUM-1];
	wire [ssc_pkg::LAN_W-1:0] lan_val [0:ssc_pkg::LAN_NUM-1];

	assign lan_inc[ssc_pkg::IX_RX_BIN5]   = {{(LW-1){1'b0}}, rx_bin5_w};
	assign lan_inc[ssc_pkg::IX_RX_OVER]   = {{(LW-1){1'b0}}, rx_over_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN0]   = {{(LW-1){1'b0}}, tx_bin0_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN1]   = {{(LW-1){1'b0}}, tx_bin1_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN2]   = {{(LW-1){1'b0}}, tx_bin2_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN3]   = {{(LW-1){1'b0}}, tx_bin3_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN4]   = {{(LW-1){1'b0}}, tx_bin4_w};
	assign lan_inc[ssc_pkg::IX_TX_BIN5]   = {{(LW-1){1'b0}}, tx_bin5_w};
	assign lan_inc[ssc_pkg::IX_TX_OVER]   = {{(LW-1){1'b0}}, tx_over_w};
	assign lan_inc[ssc_pkg::IX_RX_BYTES]  = rx_good_w ? rx_len_in : '0;
	assign lan_inc[ssc_pkg::IX_RX_RUNT]   = {{(LW-1){1'b0}}, rx_runt_w};
	assign lan_inc[ssc_pkg::IX_RX_JABBER] = {{(LW-1){1'b0}}, rx_jab_w};

	// 64-bit lan counters wrap instead of holding
	genvar gi;
	generate
		for (gi = 0; gi < ssc_pkg::LAN_NUM; gi++) begin : g_lan
			// host clear restarts the count, a same-cycle event is counted from zero
			ssc_counter #(
				.W   (ssc_pkg::LAN_W),
				.IW  (LW),
				.SAT (1'b0)
			) u_ctr (
				.mclk_in   (mclk_in),
				.resetn_in (resetn_in),
				.ce_in     (ce_in),
				.clr_in    (host_clear_in[int'(ssc_pkg::LAN_FIRST) + gi]),
				.inc_in    (lan_inc[gi]),
				.val_out   (lan_val[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// lan counter read port and cleared flags
	// ------------------------------------------------------------
	// unknown counter numbers read zero, not a neighbour
	wire [5:0] lan_off_w = lan_rd_sel_in - ssc_pkg::LAN_FIRST;
	wire       lan_hit_w = (lan_rd_sel_in >= ssc_pkg::LAN_FIRST) && (lan_rd_sel_in <= ssc_pkg::LAN_LAST);
	wire [ssc_pkg::LAN_W-1:0] lan_sel_w = lan_hit_w ? lan_val[lan_off_w[3:0]] : '0;

	logic [ssc_pkg::NUM_CTRS-1:0] flags_r;
	logic [ssc_pkg::NUM_CTRS-1:0] flags_nxt;
	// set wins over the clear of a sideband read in the same cycle
	wire [ssc_pkg::NUM_CTRS-1:0] flags_kept_w = flags_r & ~{ssc_pkg::NUM_CTRS{stats_read_in}};
	assign flags_nxt = flags_kept_w | host_clear_in;

	logic                      lan_rd_valid_r;
	logic [ssc_pkg::LAN_W-1:0] lan_rd_data_r;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_r        <= '0;
			lan_rd_valid_r <= 1'b0;
			lan_rd_data_r  <= '0;
		end else if (ce_in) begin
			flags_r        <= flags_nxt;
			lan_rd_valid_r <= lan_rd_req_in;
			if (lan_rd_req_in) begin
				lan_rd_data_r <= lan_sel_w;
			end
		end
	end

	assign lan_rd_valid_out = lan_rd_valid_r;
	assign lan_rd_data_out  = lan_rd_data_r;
	// reserved high bits always read as zero
	assign cleared_lo_out   = flags_r[ssc_pkg::FLAG_LO_BITS-1:0];
	assign cleared_hi_out   = {ssc_pkg::FLAG_HI_RSVD, flags_r[ssc_pkg::NUM_CTRS-1:ssc_pkg::FLAG_LO_BITS]};

	// ------------------------------------------------------------
	// sideband statistics counters 1 to 7
	// ------------------------------------------------------------
	// channel-id drops may be left out, chosen at build time
	wire drop_cnt_w  = msg_drop_in && (COUNT_BAD_CHAN || !drop_bad_chan_in);
	wire csum_cnt_w  = CSUM_CHECK_EN && csum_drop_in;

	wire [1:0]            sb_inc [0:ssc_pkg::SB_NUM-1];
	wire [ssc_pkg::SB_W-1:0] sb_val [0:ssc_pkg::SB_NUM-1];
	wire [ssc_pkg::SB_W-1:0] sb_rpt [0:ssc_pkg::SB_NUM-1];
	wire [ssc_pkg::SB_NUM-1:0] sb_rd_clr;
	wire [ssc_pkg::SB_NUM-1:0] sb_clr_w;
	// status word first, then the counters in number order
	wire [31:0]              word_tbl [0:ssc_pkg::SB_NUM];

	assign word_tbl[0] = {ssc_pkg::RSP_CODE_OK, ssc_pkg::RSN_CODE_NONE};

	assign sb_inc[ssc_pkg::IX_SB_CMDS]   = {1'b0, cmd_ok_in};
	assign sb_inc[ssc_pkg::IX_SB_DROPS]  = {1'b0, drop_cnt_w};
	assign sb_inc[ssc_pkg::IX_SB_UNSUPP] = {1'b0, cmd_unsupp_in};
	assign sb_inc[ssc_pkg::IX_SB_CSUM]   = {1'b0, csum_cnt_w};
	assign sb_inc[ssc_pkg::IX_SB_RX]     = {1'b0, cmd_ok_in} + {1'b0, drop_cnt_w};
	assign sb_inc[ssc_pkg::IX_SB_TX]     = {1'b0, resp_sent_in}
		+ {1'b0, async_event_notice_sent_in};
	assign sb_inc[ssc_pkg::IX_SB_NOTICE] = {1'b0, async_event_notice_sent_in};

	// saturating: all ones stays reserved for counters not built
	generate
		for (gi = 0; gi < ssc_pkg::SB_NUM; gi++) begin : g_sb
			ssc_counter #(
				.W   (ssc_pkg::SB_W),
				.IW  (2),
				.SAT (1'b1)
			) u_ctr (
				.mclk_in   (mclk_in),
				.resetn_in (resetn_in),
				.ce_in     (ce_in),
				.clr_in    (sb_clr_w[gi]),
				.inc_in    (sb_inc[gi]),
				.val_out   (sb_val[gi])
			);
			// checksum counter is unsupported when checking is not built
			if (gi == ssc_pkg::IX_SB_CSUM) begin : g_opt
				assign sb_rpt[gi] = CSUM_CHECK_EN ? sb_val[gi] : ssc_pkg::CTR_UNSUPP;
			end else begin : g_fix
				assign sb_rpt[gi] = sb_val[gi];
			end
			assign word_tbl[gi + 1] = sb_rpt[gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// command recognition and response word stream
	// ------------------------------------------------------------
	ssc_pkg::ssc_state_t state_r;
	ssc_pkg::ssc_state_t state_nxt;
	logic [2:0]          idx_r;
	logic [2:0]          idx_nxt;

	// a statistics command during a burst is dropped, not queued
	wire start_w   = cmd_valid_in && (cmd_type_in == ssc_pkg::CMD_SB_STATS);
	wire pt_w      = cmd_valid_in && (cmd_type_in == ssc_pkg::CMD_PT_STATS);
	wire sending_w = (state_r == ssc_pkg::SSC_SEND);
	wire last_w    = sending_w && (idx_r == ssc_pkg::SB_LAST_WORD);
	wire [2:0] sb_ix_w = idx_r - 3'h1;
	wire [31:0] word_w = word_tbl[idx_r];

	generate
		for (gi = 0; gi < ssc_pkg::SB_NUM; gi++) begin : g_clr
			// each counter is zeroed in the cycle its word is captured
			assign sb_rd_clr[gi] = sending_w && (sb_ix_w == 3'(gi)) && (idx_r != 3'h0);
			assign sb_clr_w[gi]  = init_state_in || sb_rd_clr[gi];
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		unique case (state_r)
			ssc_pkg::SSC_IDLE: begin
				if (start_w) begin
					state_nxt = ssc_pkg::SSC_SEND;
					idx_nxt   = 3'h0;
				end
			end
			ssc_pkg::SSC_SEND: begin
				idx_nxt = idx_r + 3'h1;
				if (last_w) begin
					state_nxt = ssc_pkg::SSC_IDLE;
				end
			end
		endcase
	end

	// type stays at the response value once a burst is out
	logic        resp_valid_r;
	logic        resp_last_r;
	logic [7:0]  resp_type_r;
	logic [31:0] resp_word_r;
	logic        pt_req_r;

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r      <= ssc_pkg::SSC_IDLE;
			idx_r        <= 3'h0;
			resp_valid_r <= 1'b0;
			resp_last_r  <= 1'b0;
			resp_type_r  <= 8'h00;
			resp_word_r  <= 32'h00000000;
			pt_req_r     <= 1'b0;
		end else if (ce_in) begin
			state_r      <= state_nxt;
			idx_r        <= idx_nxt;
			resp_valid_r <= sending_w;
			resp_last_r  <= last_w;
			pt_req_r     <= pt_w;
			if (sending_w) begin
				resp_type_r <= ssc_pkg::RSP_SB_STATS;
				resp_word_r <= word_w;
			end
		end
	end

	assign resp_valid_out = resp_valid_r;
	assign resp_last_out  = resp_last_r;
	assign resp_type_out  = resp_type_r;
	assign resp_word_out  = resp_word_r;
	assign pt_req_out     = pt_req_r;
endmodule : ssc_stats

// [tb/ssc_stats_monitor.sv]
// assertion checker for the statistics counter block
`timescale 1ns/1ps
module ssc_stats_monitor #(
	parameter bit CSUM_CHECK_EN = 1'b1
) (
	input wire logic        mclk_in,
	input wire logic        resetn_in,
	input wire logic        ce_in,
	input wire logic [38:0] host_clear_in,
	input wire logic        stats_read_in,
	input wire logic        lan_rd_req_in,
	input wire logic        cmd_valid_in,
	input wire logic [7:0]  cmd_type_in,
	input wire logic        lan_rd_valid_out,
	input wire logic [31:0] cleared_lo_out,
	input wire logic [31:0] cleared_hi_out,
	input wire logic        resp_valid_out,
	input wire logic        resp_last_out,
	input wire logic [7:0]  resp_type_out,
	input wire logic [31:0] resp_word_out,
	input wire logic        pt_req_out
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	property p_burst; $rose(resp_valid_out) |-> resp_valid_out [*8] ##1 !resp_valid_out; endproperty
	a_burst: assert property (p_burst) else $error("response burst length wrong");
	property p_last; resp_last_out |-> resp_valid_out && $past(resp_valid_out, 7) && !$past(resp_valid_out, 8); endproperty
	a_last: assert property (p_last) else $error("last word out of place");
	property p_start; $rose(resp_valid_out) |-> $past(ce_in && cmd_valid_in && cmd_type_in == 8'h19, 2); endproperty
	a_start: assert property (p_start) else $error("response without statistics command");
	property p_type; resp_valid_out |-> resp_type_out == 8'h99; endproperty
	a_type: assert property (p_type) else $error("response type wrong");
	property p_word0; $rose(resp_valid_out) |-> resp_word_out == 32'h00000000; endproperty
	a_word0: assert property (p_word0) else $error("response code word not zero");
	property p_ones; resp_valid_out && CSUM_CHECK_EN |-> resp_word_out != 32'hFFFFFFFF; endproperty
	a_ones: assert property (p_ones) else $error("supported counter shows all ones");
	property p_pt; ce_in && cmd_valid_in && cmd_type_in == 8'h1A |=> pt_req_out; endproperty
	a_pt: assert property (p_pt) else $error("pass-through command missed");
	property p_pt_cause; pt_req_out |-> $past(cmd_valid_in && cmd_type_in == 8'h1A); endproperty
	a_pt_cause: assert property (p_pt_cause) else $error("pass-through request without command");
	property p_rsvd; cleared_hi_out[31:7] == 25'h0000000; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved flag bits set");
	property p_fset;
		ce_in && |host_clear_in |=> ({cleared_hi_out[6:0], cleared_lo_out} & $past(host_clear_in)) == $past(host_clear_in);
	endproperty
	a_fset: assert property (p_fset) else $error("cleared flag not set");
	property p_fclr; ce_in && stats_read_in && host_clear_in == 39'h0 |=> {cleared_hi_out, cleared_lo_out} == 64'h0; endproperty
	a_fclr: assert property (p_fclr) else $error("cleared flags survive read");
	property p_rd; ce_in && lan_rd_req_in |=> lan_rd_valid_out; endproperty
	a_rd: assert property (p_rd) else $error("counter read not answered");
	c_burst: cover property (resp_last_out);
	c_pt: cover property (pt_req_out);
	c_flag: cover property (cleared_hi_out != 32'h00000000);
endmodule : ssc_stats_monitor
bind ssc_stats ssc_stats_monitor #(.CSUM_CHECK_EN(CSUM_CHECK_EN)) u_ssc_stats_monitor (
	.mclk_in, .resetn_in, .ce_in, .host_clear_in, .stats_read_in, .lan_rd_req_in, .cmd_valid_in,
	.cmd_type_in, .lan_rd_valid_out, .cleared_lo_out, .cleared_hi_out, .resp_valid_out,
	.resp_last_out, .resp_type_out, .resp_word_out, .pt_req_out);

// [tb/ssc_mgmt_model.sv]
// management controller model: issues commands and collects response words
`timescale 1ns/1ps
module ssc_mgmt_model (
	input  wire logic        mclk_in,
	output logic             cmd_valid_out,
	output logic [7:0]       cmd_type_out,
	input  wire logic        resp_valid_in,
	input  wire logic        resp_last_in,
	input  wire logic [31:0] resp_word_in
);
	logic [31:0] words [8];
	int          n_words;
	int          last_at;
	initial begin
		cmd_valid_out = 1'b0;
		cmd_type_out  = 8'h00;
		n_words       = 0;
		last_at       = 0;
	end
	task clear_words;
		n_words = 0;
		last_at = 0;
	endtask : clear_words
	task send(input logic [7:0] t);
		cmd_valid_out = 1'b1;
		cmd_type_out  = t;
		@(posedge mclk_in);
		#2;
		cmd_valid_out = 1'b0;
		// type byte is not held once the command is gone
		cmd_type_out  = ~t;
		@(posedge mclk_in);
		#2;
	endtask : send
	always @(posedge mclk_in) begin
		if (resp_valid_in === 1'b1) begin
			words[n_words[2:0]] = resp_word_in;
			n_words = n_words + 1;
			if (resp_last_in === 1'b1) last_at = n_words;
		end
	end
endmodule : ssc_mgmt_model

// [tb/ssc_stats_bench.sv]
// self-checking bench for the statistics counter block
`timescale 1ns/1ps
module ssc_stats_bench;
	logic        mclk_in, resetn_in, ce_in, rx_done_in, rx_fcs_ok_in, rx_err_in, rx_addr_pass_in;
	logic        tx_done_in, tx_good_in, tx_addr_pass_in, stats_read_in, lan_rd_req_in, init_state_in;
	logic        cmd_ok_in, msg_drop_in, drop_bad_chan_in, cmd_unsupp_in, csum_drop_in, resp_sent_in;
	logic        async_event_notice_sent_in, cmd_valid_in, lan_rd_valid_out, resp_valid_out;
	logic        resp_last_out, pt_req_out;
	logic [13:0] rx_len_in, rx_mtu_in, tx_len_in;
	logic [38:0] host_clear_in;
	logic [5:0]  lan_rd_sel_in;
	logic [7:0]  cmd_type_in, resp_type_out;
	logic [63:0] lan_rd_data_out;
	logic [31:0] cleared_lo_out, cleared_hi_out, resp_word_out;
	logic [31:0] exp_w [8];
	int          failures, n_compared, cyc, pt_seen;
	ssc_stats u_ssc_stats (.mclk_in, .resetn_in, .ce_in, .rx_done_in, .rx_len_in, .rx_fcs_ok_in, .rx_err_in,
		.rx_addr_pass_in, .rx_mtu_in, .tx_done_in, .tx_len_in, .tx_good_in, .tx_addr_pass_in, .host_clear_in,
		.stats_read_in, .lan_rd_req_in, .lan_rd_sel_in, .init_state_in, .cmd_ok_in, .msg_drop_in,
		.drop_bad_chan_in, .cmd_unsupp_in, .csum_drop_in, .resp_sent_in, .async_event_notice_sent_in,
		.cmd_valid_in, .cmd_type_in, .lan_rd_valid_out, .lan_rd_data_out, .cleared_lo_out, .cleared_hi_out,
		.resp_valid_out, .resp_last_out, .resp_type_out, .resp_word_out, .pt_req_out);
	ssc_mgmt_model u_ssc_mgmt_model (.mclk_in, .cmd_valid_out(cmd_valid_in), .cmd_type_out(cmd_type_in),
		.resp_valid_in(resp_valid_out), .resp_last_in(resp_last_out), .resp_word_in(resp_word_out));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (pt_req_out === 1'b1) pt_seen++;
		if (cyc == 5000) begin
			failures++;
			print_verdict();
		end
	end
	task tick;
		@(posedge mclk_in);
		#2;
	endtask : tick
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task rx(input logic [13:0] l, input logic f, input logic er, input logic p);
		{rx_done_in, rx_fcs_ok_in, rx_err_in, rx_addr_pass_in} = {1'b1, f, er, p};
		rx_len_in = l;
		tick();
	endtask : rx
	task tx(input logic [13:0] l, input logic p);
		{tx_done_in, tx_good_in, tx_addr_pass_in} = {1'b1, 1'b1, p};
		tx_len_in = l;
		tick();
	endtask : tx
	task ev(input logic [5:0] v);
		{cmd_ok_in, msg_drop_in, cmd_unsupp_in, csum_drop_in, resp_sent_in, async_event_notice_sent_in} = v;
		tick();
	endtask : ev
	task rd(input logic [5:0] s, input logic [63:0] e);
		lan_rd_sel_in = s;
		lan_rd_req_in = 1'b1;
		tick();
		lan_rd_req_in = 1'b0;
		chk("lan_rd_valid_out", 64'h1, {63'h0, lan_rd_valid_out});
		chk("lan_rd_data_out", e, lan_rd_data_out);
		tick();
	endtask : rd
	task sb_read(input logic dbl);
		u_ssc_mgmt_model.clear_words();
		u_ssc_mgmt_model.send(8'h19);
		// a second command inside the burst must be ignored
		if (dbl) u_ssc_mgmt_model.send(8'h19);
		for (int i = 0; i < 20 && u_ssc_mgmt_model.n_words < 8; i++) tick();
		repeat (4) tick();
		chk("response word count", 64'h8, 64'(u_ssc_mgmt_model.n_words));
		chk("resp_last_out word", 64'h8, 64'(u_ssc_mgmt_model.last_at));
		for (int i = 0; i < 8; i++) chk("resp_word_out", {32'h0, exp_w[i]}, {32'h0, u_ssc_mgmt_model.words[i]});
		chk("resp_type_out", 64'h99, {56'h0, resp_type_out});
	endtask : sb_read
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_rx;
		rx(14'h0400, 1'b1, 1'b0, 1'b1);
		rx(14'h05F2, 1'b1, 1'b0, 1'b1);
		rx(14'h05F3, 1'b0, 1'b0, 1'b1);
		rx(14'h05F4, 1'b1, 1'b1, 1'b1);
		rx(14'h003F, 1'b0, 1'b0, 1'b0);
		rx(14'h0040, 1'b0, 1'b0, 1'b0);
		rx(14'h044C, 1'b1, 1'b0, 1'b0);
		// a frame while ce is low must not be counted
		ce_in = 1'b0;
		rx(14'h0400, 1'b1, 1'b0, 1'b1);
		ce_in = 1'b1;
		rx_done_in = 1'b0;
		tick();
		rd(6'h1B, 64'h3);
		rd(6'h1C, 64'h1);
		rd(6'h24, 64'hE3E);
		rd(6'h25, 64'h1);
		rd(6'h26, 64'h1);
	endtask : t_rx
	task t_tx;
		tx(14'h0040, 1'b0);
		tx(14'h007F, 1'b0);
		tx(14'h0080, 1'b0);
		tx(14'h01FF, 1'b0);
		tx(14'h03FF, 1'b0);
		tx(14'h05F2, 1'b0);
		tx(14'h003F, 1'b1);
		tx(14'h05F3, 1'b1);
		tx(14'h0640, 1'b1);
		tx_done_in = 1'b0;
		tick();
		for (int s = 29; s <= 34; s++) rd(6'(s), 64'h1);
		rd(6'h23, 64'h1);
	endtask : t_tx
	task t_clear;
		host_clear_in = 39'h0208000000;
		rx(14'h0406, 1'b1, 1'b0, 1'b0);
		host_clear_in = 39'h0;
		rx_done_in = 1'b0;
		tick();
		chk("cleared_lo_out", 64'h08000000, {32'h0, cleared_lo_out});
		chk("cleared_hi_out", 64'h2, {32'h0, cleared_hi_out});
		rd(6'h1B, 64'h1);
		rd(6'h21, 64'h0);
		stats_read_in = 1'b1;
		tick();
		stats_read_in = 1'b0;
		tick();
		chk("cleared flags", 64'h0, {cleared_hi_out, cleared_lo_out});
		// a host clear in the read cycle keeps its flag
		host_clear_in = 39'h4000000000;
		stats_read_in = 1'b1;
		tick();
		{host_clear_in, stats_read_in} = '0;
		tick();
		chk("cleared_hi_out", 64'h40, {32'h0, cleared_hi_out});
	endtask : t_clear
	task t_sb;
		ev(6'b110011);
		ev(6'b111100);
		ev(6'b100010);
		// a drop for a bad channel id is left out of counters 2 and 5
		drop_bad_chan_in = 1'b1;
		ev(6'b010000);
		drop_bad_chan_in = 1'b0;
		ev(6'b000000);
		exp_w = '{32'h0, 32'h3, 32'h2, 32'h1, 32'h1, 32'h5, 32'h3, 32'h1};
		sb_read(1'b1);
		exp_w = '{default: 32'h0};
		sb_read(1'b0);
		ev(6'b110011);
		ev(6'b000000);
		init_state_in = 1'b1;
		tick();
		init_state_in = 1'b0;
		tick();
		sb_read(1'b0);
	endtask : t_sb
	task t_pt;
		u_ssc_mgmt_model.clear_words();
		u_ssc_mgmt_model.send(8'h1A);
		u_ssc_mgmt_model.send(8'h05);
		repeat (12) tick();
		chk("pt_req_out pulses", 64'h1, 64'(pt_seen));
		chk("unasked response words", 64'h0, 64'(u_ssc_mgmt_model.n_words));
	endtask : t_pt
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial begin
		{resetn_in, rx_done_in, rx_fcs_ok_in, rx_err_in, rx_addr_pass_in, tx_done_in, tx_good_in} = 7'h00;
		{tx_addr_pass_in, stats_read_in, lan_rd_req_in, init_state_in, drop_bad_chan_in} = 5'h00;
		{cmd_ok_in, msg_drop_in, cmd_unsupp_in, csum_drop_in, resp_sent_in, async_event_notice_sent_in} = 6'h00;
		{rx_len_in, tx_len_in, host_clear_in, lan_rd_sel_in} = '0;
		ce_in = 1'b1;
		rx_mtu_in = 14'h05EE;
		repeat (10) @(posedge mclk_in);
		#2;
		resetn_in = 1'b1;
		tick();
		chk("reset outputs", 64'h0, {resp_valid_out, pt_req_out, resp_type_out, cleared_hi_out[6:0], cleared_lo_out});
		t_rx();
		t_tx();
		t_clear();
		t_sb();
		t_pt();
		print_verdict();
	end
endmodule : ssc_stats_bench
